// ---- dv/pin_side_model.sv ----
// External signals on the general I/O lines, with pull-ups on released lines
`timescale 1ns/1ps
module pin_side_model (
  input wire [15:0] drv_lvl_i,  // Level the unit drives
  input wire [15:0] drv_oe_n_i, // Unit enable, low drives
  input wire [15:0] ext_lvl_i,  // Far-side source, high = released to pull-up
  output wire [15:0] io_in_o    // Resolved line level
);
  // Driven lines read back their own level; others follow the far side
  assign io_in_o = (~drv_oe_n_i & drv_lvl_i) | (drv_oe_n_i & ext_lvl_i);
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the timer/counter unit
`timescale 1ns/1ps
module tb;
  reg clk_sys_i, arst_n_i, err_suppress_i, cfg_wr_i, cfg_cnt0_en_i, cfg_cnt1_en_i;
  reg tmr_wr_i, tmr_sel_i, cnt_rd_i, cnt_rst_i, cnt_sel_i, err_clr_i, gpio_dir_wr_i;
  reg [1:0] hw_rev_i, cfg_tmr_num_i;
  reg [3:0] cfg_pin_base_i, tmr_mode_i;
  reg [2:0] cfg_tick_src_i;
  reg [7:0] cfg_prescale_i;
  reg [15:0] tmr_value_i, gpio_out_i, gpio_oe_n_i, ext_lvl;
  wire [15:0] io_in_i, io_out_o, io_oe_n_o;
  wire [31:0] cnt_rd_data_o;
  wire cnt_rd_vld_o, cfg_err_o, cnt0_avail_o, tick_o;
  integer error_cnt, n_checks, cyc, i, n, lo, hi;
  timer_counter_pwm_unit u_timer_counter_pwm_unit (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .hw_rev_i(hw_rev_i), .err_suppress_i(err_suppress_i),
    .cfg_wr_i(cfg_wr_i), .cfg_tmr_num_i(cfg_tmr_num_i), .cfg_cnt0_en_i(cfg_cnt0_en_i),
    .cfg_cnt1_en_i(cfg_cnt1_en_i), .cfg_pin_base_i(cfg_pin_base_i),
    .cfg_tick_src_i(cfg_tick_src_i), .cfg_prescale_i(cfg_prescale_i), .tmr_wr_i(tmr_wr_i),
    .tmr_sel_i(tmr_sel_i), .tmr_mode_i(tmr_mode_i), .tmr_value_i(tmr_value_i),
    .cnt_rd_i(cnt_rd_i), .cnt_rst_i(cnt_rst_i), .cnt_sel_i(cnt_sel_i), .err_clr_i(err_clr_i),
    .gpio_dir_wr_i(gpio_dir_wr_i), .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i),
    .io_in_i(io_in_i), .io_out_o(io_out_o), .io_oe_n_o(io_oe_n_o),
    .cnt_rd_data_o(cnt_rd_data_o), .cnt_rd_vld_o(cnt_rd_vld_o), .cfg_err_o(cfg_err_o),
    .cnt0_avail_o(cnt0_avail_o), .tick_o(tick_o));
  pin_side_model u_pin_side_model (.drv_lvl_i(io_out_o), .drv_oe_n_i(io_oe_n_o),
    .ext_lvl_i(ext_lvl), .io_in_o(io_in_i));
  // 125 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task finish_test;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Tick phase makes counts wobble by one
  task chk_near(input [31:0] got, input [31:0] exp);
    chk((got + 1 >= exp && got <= exp + 1) ? exp : got, exp);
  endtask
  task cfg(input [1:0] tn, input c0, input c1, input [3:0] base, input [2:0] src,
    input [7:0] pre);
    begin
      @(negedge clk_sys_i);
      {cfg_tmr_num_i, cfg_cnt0_en_i, cfg_cnt1_en_i} = {tn, c0, c1};
      {cfg_pin_base_i, cfg_tick_src_i, cfg_prescale_i} = {base, src, pre};
      cfg_wr_i = 1'b1;
      @(negedge clk_sys_i);
      cfg_wr_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask
  task tmr(input sel, input [3:0] mode, input [15:0] val);
    begin
      @(negedge clk_sys_i);
      {tmr_sel_i, tmr_mode_i, tmr_value_i} = {sel, mode, val};
      tmr_wr_i = 1'b1;
      @(negedge clk_sys_i);
      tmr_wr_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask
  task clr_err;
    begin
      err_clr_i = 1'b1;
      @(negedge clk_sys_i);
      err_clr_i = 1'b0;
      @(negedge clk_sys_i);
    end
  endtask
  task pulse(input [3:0] ln, input integer cnt);
    repeat (cnt) begin
      ext_lvl[ln] = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      ext_lvl[ln] = 1'b1;
      repeat (4) @(negedge clk_sys_i);
    end
  endtask
  task rd(input sel, input rst, input [31:0] exp);
    begin
      {cnt_sel_i, cnt_rd_i, cnt_rst_i} = {sel, 1'b1, rst};
      @(negedge clk_sys_i);
      {cnt_rd_i, cnt_rst_i} = 2'b00;
      chk(cnt_rd_vld_o, 1);
      chk(cnt_rd_data_o, exp);
      @(negedge clk_sys_i);
    end
  endtask
  task ticks(input integer w, output integer cnt);
    begin
      cnt = 0;
      repeat (w) begin
        @(negedge clk_sys_i);
        if (tick_o === 1'b1) cnt = cnt + 1;
      end
    end
  endtask
  // Low then high phase of line 4, in ticks, ending at the next fall
  task pwm_meas(output integer l, output integer h);
    integer k;
    begin
      k = 0;
      l = 0;
      h = 0;
      while (io_out_o[4] !== 1'b0 && k < 2000) begin
        @(negedge clk_sys_i);
        k = k + 1;
      end
      while (io_out_o[4] === 1'b0 && k < 4000) begin
        @(negedge clk_sys_i);
        k = k + 1;
        if (tick_o === 1'b1) l = l + 1;
      end
      while (io_out_o[4] === 1'b1 && k < 6000) begin
        @(negedge clk_sys_i);
        k = k + 1;
        if (tick_o === 1'b1) h = h + 1;
      end
    end
  endtask
  function integer src_khz(input integer s);
    case (s)
      0, 4: src_khz = 4000;
      1, 5: src_khz = 12000;
      2, 6: src_khz = 48000;
      default: src_khz = 1000;
    endcase
  endfunction
  // Hang guard, well above the expected run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  initial begin
    {error_cnt, n_checks, cyc} = 0;
    {arst_n_i, err_suppress_i, cfg_wr_i, tmr_wr_i, cnt_rd_i, cnt_rst_i} = 6'h00;
    {cfg_cnt0_en_i, cfg_cnt1_en_i, tmr_sel_i, cnt_sel_i, err_clr_i, gpio_dir_wr_i} = 6'h00;
    {hw_rev_i, cfg_tmr_num_i, cfg_pin_base_i, cfg_tick_src_i} = {2'h2, 2'h0, 4'h4, 3'h2};
    {cfg_prescale_i, tmr_mode_i, tmr_value_i} = {8'h01, 4'hA, 16'h0000};
    {gpio_out_i, gpio_oe_n_i, ext_lvl} = {16'h0000, 16'hFFFF, 16'hFFFF};
    repeat (16) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk({io_out_o, io_oe_n_o}, 32'h0000FFFF);
    chk({cfg_err_o, cnt0_avail_o}, 2'b01);
    // Every selector at prescale 2, then prescale 0 and the halved revision
    for (i = 0; i < 7; i = i + 1) begin
      cfg(0, 0, 0, 4, i, 2);
      ticks(1250, n);
      chk_near(n, src_khz(i) / 100 / ((i > 2) ? 2 : 1));
    end
    cfg(0, 0, 0, 4, 6, 0);
    ticks(12500, n);
    chk_near(n, 18);
    hw_rev_i = 2'h0;
    cfg(0, 0, 0, 4, 2, 1);
    ticks(1250, n);
    chk_near(n, 240);
    hw_rev_i = 2'h2;
    // Strap needs two edges through its synchroniser before a write may rely on it
    repeat (2) @(negedge clk_sys_i);
    // Refused configurations leave the old setting
    cfg(0, 0, 0, 9, 2, 1);
    chk(cfg_err_o, 1);
    clr_err;
    cfg(0, 0, 0, 2, 2, 1);
    chk(cfg_err_o, 1);
    clr_err;
    chk(cfg_err_o, 0);
    cfg(1, 1, 0, 4, 2, 1);
    cfg(1, 1, 0, 4, 3, 1);
    chk({cfg_err_o, cnt0_avail_o}, 2'b11);
    clr_err;
    cfg(1, 0, 0, 4, 3, 1);
    chk({cfg_err_o, cnt0_avail_o}, 2'b00);
    cfg(1, 1, 0, 4, 3, 1);
    chk(cfg_err_o, 1);
    clr_err;
    tmr(1, 14, 0);
    chk(cfg_err_o, 1);
    clr_err;
    tmr(0, 9, 0);
    chk(cfg_err_o, 1);
    clr_err;
    for (i = 0; i < 14; i = i + 1) tmr(1, i, 0);
    chk(cfg_err_o, 0);
    // All four channels from base 8, timers as steady-high outputs
    tmr(0, 0, 0);
    tmr(1, 0, 0);
    cfg(2, 1, 1, 8, 2, 1);
    chk({io_oe_n_o[11:8], io_out_o[9:8]}, 6'b1100_11);
    pulse(10, 3);
    pulse(11, 1);
    rd(0, 0, 3);
    rd(1, 0, 1);
    rd(0, 1, 3);
    rd(0, 0, 0);
    cfg(1, 0, 1, 6, 2, 1);
    chk({io_oe_n_o[9:6]}, 4'b0010);
    pulse(7, 2);
    rd(1, 0, 3);
    cfg(1, 0, 1, 4, 3, 1);
    pulse(5, 1);
    rd(1, 0, 4);
    chk(io_oe_n_o[4], 0);
    err_suppress_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    cfg(2, 0, 0, 1, 2, 1);
    chk({cfg_err_o, io_oe_n_o[5:4], io_oe_n_o[1]}, 4'b0001);
    // Host takes the free lines back; channel lines stay put
    {gpio_oe_n_i, gpio_dir_wr_i} = {16'hFFFE, 1'b1};
    @(negedge clk_sys_i);
    gpio_dir_wr_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk({io_oe_n_o[9:8], io_oe_n_o[5:4], io_oe_n_o[0], io_out_o[0]}, 6'b11_00_00);
    // 8-bit PWM: upper byte only, shared falling edge, duty change at boundary
    tmr(0, 1, 16'h4012);
    tmr(1, 1, 16'h8000);
    pwm_meas(lo, hi);
    pwm_meas(lo, hi);
    chk_near(lo, 64);
    chk_near(hi, 192);
    chk(io_out_o[5], 0);
    tmr(0, 1, 16'h20FF);
    pwm_meas(lo, hi);
    pwm_meas(lo, hi);
    chk_near(lo, 32);
    finish_test;
  end
endmodule

// ---- dv/tc_unit_assertions.sv ----
// Concurrent checks on the timer/counter unit ports
`timescale 1ns/1ps
module tc_unit_checker (
  input wire clk_sys_i,            // System clock
  input wire arst_n_i,             // Async reset, active low
  input wire cfg_wr_i,             // Config write
  input wire cfg_cnt0_en_i,        // First counter enable
  input wire [3:0] cfg_pin_base_i, // Pin base
  input wire [2:0] cfg_tick_src_i, // Tick source
  input wire tmr_wr_i,             // Timer write
  input wire tmr_sel_i,            // Timer index
  input wire [3:0] tmr_mode_i,     // Timer mode
  input wire cnt_rd_i,             // Counter read
  input wire err_clr_i,            // Error clear
  input wire cfg_err_o,            // Sticky error
  input wire cnt_rd_vld_o,         // Read valid
  input wire cnt0_avail_o,         // First counter available
  input wire tick_o                // Shared tick
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Error flag: held until cleared, raised only by a write
  a_err_sticky: assert property (cfg_err_o && !err_clr_i |=> cfg_err_o)
    else $error("error flag dropped without clear");
  a_err_cause: assert property ($rose(cfg_err_o) |-> $past(cfg_wr_i) || $past(tmr_wr_i))
    else $error("error flag rose without a write");
  a_err_base: assert property (cfg_wr_i && cfg_pin_base_i > 4'h8 |=> cfg_err_o)
    else $error("pin base above range accepted");
  a_err_cnt0: assert property (cfg_wr_i && cfg_cnt0_en_i
    && cfg_tick_src_i >= 3'h3 |=> cfg_err_o)
    else $error("first counter with divided tick accepted");
  a_err_mode: assert property (tmr_wr_i && tmr_mode_i > 4'hD |=> cfg_err_o)
    else $error("timer mode above range accepted");
  a_err_stop: assert property (tmr_wr_i && !tmr_sel_i
    && tmr_mode_i == 4'h9 |=> cfg_err_o)
    else $error("stop mode accepted on even timer");
  // Availability moves only as a consequence of a config write
  a_avail_cause: assert property ($changed(cnt0_avail_o)
    |-> $past(cfg_wr_i) || $past(cfg_wr_i, 2))
    else $error("counter availability changed without config");
  // Read answer is a single-cycle pulse tied to its request
  a_rd_answer: assert property (cnt_rd_i |=> cnt_rd_vld_o)
    else $error("read not answered in one cycle");
  a_vld_cause: assert property (cnt_rd_vld_o |-> $past(cnt_rd_i))
    else $error("read valid without request");
  // Tick never exceeds half the system rate, so it is a lone pulse
  a_tick_single: assert property (tick_o |=> !tick_o)
    else $error("tick wider than one cycle");
endmodule
bind timer_counter_pwm_unit tc_unit_checker u_tc_unit_checker (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i),
  .cfg_cnt0_en_i(cfg_cnt0_en_i), .cfg_pin_base_i(cfg_pin_base_i),
  .cfg_tick_src_i(cfg_tick_src_i), .tmr_wr_i(tmr_wr_i), .tmr_sel_i(tmr_sel_i),
  .tmr_mode_i(tmr_mode_i), .cnt_rd_i(cnt_rd_i), .err_clr_i(err_clr_i),
  .cfg_err_o(cfg_err_o), .cnt_rd_vld_o(cnt_rd_vld_o), .cnt0_avail_o(cnt0_avail_o),
  .tick_o(tick_o));

// ---- verilog/edge_tally.v ----
// One 32-bit falling-edge counter with reset and read-before-reset
`timescale 1ns/1ps
module edge_tally (
  input wire clk_sys_i,          // System clock
  input wire arst_n_i,           // Async reset, active low
  input wire en_i,               // Counter enabled and available
  input wire line_i,             // Synchronised input line
  input wire clr_i,              // Reset count, one-cycle pulse
  output reg [31:0] count_o      // Running count
);

  reg line_q;

  // Falling edge detector on an already synchronised line
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_q <= 1'b1;
    end else begin
      line_q <= line_i;
    end
  end

  // Count, reset wins but an edge in that same cycle still counts once
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= 32'h00000000;
    end else if (clr_i) begin
      count_o <= {31'h00000000, en_i & line_q & ~line_i};
    end else if (en_i && line_q && !line_i) begin
      count_o <= count_o + 32'h00000001; // [RL11]
    end
  end

endmodule

// ---- verilog/tc_unit_map.vh ----
// Constants for the timer/counter unit: codes, limits, reset values, rates
`ifndef TC_UNIT_MAP_VH
`define TC_UNIT_MAP_VH

// System clock and tick source rates, in kHz
`define CLK_SYS_KHZ 17'd125000
`define SRC_1MHZ_KHZ 17'd1000
`define SRC_4MHZ_KHZ 17'd4000
`define SRC_12MHZ_KHZ 17'd12000
`define SRC_48MHZ_KHZ 17'd48000

// Tick source selector codes
`define SRC_4M 3'h0
`define SRC_12M 3'h1
`define SRC_48M 3'h2
`define SRC_1M_DIV 3'h3
`define SRC_4M_DIV 3'h4
`define SRC_12M_DIV 3'h5
`define SRC_48M_DIV 3'h6
`define SRC_LAST 3'h6

// Hardware revision codes
`define REV_OLDEST 2'h0
`define REV_MIDDLE 2'h1
`define REV_NEWEST 2'h2

// Pin base limits and substitute value
`define PIN_BASE_MIN 4'h4
`define PIN_BASE_MAX 4'h8
`define PIN_BASE_SUBST 4'h4

// Timer mode codes and timer count limit
`define MODE_PWM16 4'h0
`define MODE_PWM8 4'h1
`define MODE_STOP 4'h9
`define MODE_SYS_LOW 4'hA
`define MODE_LAST 4'hD
`define MAX_TIMERS 2'h2

// Reset values
`define RST_TICK_SRC 3'h2
`define RST_PRESCALE 8'h01
`define RST_PIN_BASE 4'h4
`define RST_TMR_MODE 4'hA

`endif

// ---- verilog/timer_counter_pwm_unit.v ----
// Timer/counter unit: pin mapping, config checks, shared tick, PWM, edge counters
//
// Behaviour
// RL1 - Enabled channels packed in order from base
// RL2 - All four on base 8 use lines 8-11
// RL3 - Newest revision: base 0-3 is an error
// RL4 - Error suppressed: base 0-3 becomes 4
// RL5 - Only timers and counters move; others fixed
// RL6 - First counter unavailable with divided tick sources
// RL7 - Unavailable first counter takes no line
// RL8 - Enabling first counter on divided source errors
// RL9 - Divided source while first counter enabled errors
// RL10 - Assigned line direction set, kept after disable
// RL11 - Counters: 32-bit, count falling edges
// RL12 - Reset-and-read returns pre-reset count
// RL13 - Timer mode codes 0 to 13
// RL14 - Timer-stop mode only on odd timers
// RL15 - Tick selector: three fixed, four divided rates
// RL16 - Divisor 8-bit, zero means 256
// RL17 - Oldest revision halves every tick rate
// RL18 - 16-bit PWM: value is low ticks of 65536
// RL19 - 8-bit PWM uses upper byte, 256 period
// RL20 - Shared tick aligns all PWM falling edges
// RL21 - PWM period starts low, then high
// RL22 - New PWM waits for period counter wrap
// RL23 - Duty change applies at period boundary
// RL24 - Errors sticky; bad writes change nothing
`timescale 1ns/1ps
`include "tc_unit_map.vh"
module timer_counter_pwm_unit (
  input wire clk_sys_i,          // System clock, 125 MHz
  input wire arst_n_i,           // Async reset, active low
  input wire [1:0] hw_rev_i,     // Revision strap, asynchronous level
  input wire err_suppress_i,     // Power-up option: suppress base error
  input wire cfg_wr_i,           // Channel config write pulse
  input wire [1:0] cfg_tmr_num_i, // Number of timers enabled, 0 to 2
  input wire cfg_cnt0_en_i,      // First edge counter enable
  input wire cfg_cnt1_en_i,      // Second edge counter enable
  input wire [3:0] cfg_pin_base_i, // Channel pin base
  input wire [2:0] cfg_tick_src_i, // Tick source select
  input wire [7:0] cfg_prescale_i, // Tick prescale divisor
  input wire tmr_wr_i,           // Timer mode/value write pulse
  input wire tmr_sel_i,          // Timer index for the write
  input wire [3:0] tmr_mode_i,   // Timer mode code
  input wire [15:0] tmr_value_i, // Timer value
  input wire cnt_rd_i,           // Edge counter read pulse
  input wire cnt_rst_i,          // Edge counter reset pulse
  input wire cnt_sel_i,          // Edge counter index
  input wire err_clr_i,          // Clear sticky error pulse
  input wire gpio_dir_wr_i,      // Host retakes direction of free lines
  input wire [15:0] gpio_out_i,  // Host level for free lines
  input wire [15:0] gpio_oe_n_i, // Host enable for free lines, low drives
  input wire [15:0] io_in_i,     // Line levels from pins
  output reg [15:0] io_out_o,    // Line output levels
  output reg [15:0] io_oe_n_o,   // Line output enables, low drives
  output reg [31:0] cnt_rd_data_o, // Edge counter read data
  output reg cnt_rd_vld_o,       // Read data valid pulse
  output reg cfg_err_o,          // Sticky configuration error
  output reg cnt0_avail_o,       // First counter available
  output reg tick_o              // Shared timer tick pulse
);

  // Active configuration
  reg [1:0] tmr_num;
  reg cnt0_en;
  reg cnt1_en;
  reg [3:0] pin_base;
  reg [2:0] tick_src;
  reg [7:0] prescale;
  reg [3:0] tmr_mode [0:1];
  reg [15:0] tmr_pend [0:1];

  // Straps and pins cross in through two flops
  reg [1:0] rev_s1;
  reg [1:0] rev;
  reg sup_s1;
  reg sup;
  reg [15:0] in_s1;
  reg [15:0] in_s;

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rev_s1 <= 2'h0;
      rev <= 2'h0;
      sup_s1 <= 1'b0;
      sup <= 1'b0;
      in_s1 <= 16'hFFFF;
      in_s <= 16'hFFFF;
    end else begin
      rev_s1 <= hw_rev_i;
      rev <= rev_s1;
      sup_s1 <= err_suppress_i;
      sup <= sup_s1;
      in_s1 <= io_in_i;
      in_s <= in_s1;
    end
  end

  // Config write check
  wire new_div = (cfg_tick_src_i >= `SRC_1M_DIV);
  wire low_base = (cfg_pin_base_i < `PIN_BASE_MIN) && (rev == `REV_NEWEST);
  wire base_err = (low_base && !sup) || (cfg_pin_base_i > `PIN_BASE_MAX); // [RL3]
  wire div_err = new_div && cfg_cnt0_en_i; // [RL8] [RL9]
  wire cfg_bad = base_err || div_err || (cfg_tick_src_i > `SRC_LAST)
                 || (cfg_tmr_num_i > `MAX_TIMERS);
  wire [3:0] eff_base = low_base ? `PIN_BASE_SUBST : cfg_pin_base_i; // [RL4]

  // Timer write check: odd-only stop mode and mode range
  wire tmr_bad = (tmr_mode_i > `MODE_LAST) ||
                 ((tmr_mode_i == `MODE_STOP) && !tmr_sel_i); // [RL13] [RL14]

  // Rejected writes leave settings untouched
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmr_num <= 2'h0;
      cnt0_en <= 1'b0;
      cnt1_en <= 1'b0;
      pin_base <= `RST_PIN_BASE;
      tick_src <= `RST_TICK_SRC;
      prescale <= `RST_PRESCALE;
    end else if (cfg_wr_i && !cfg_bad) begin
      tmr_num <= cfg_tmr_num_i;
      cnt0_en <= cfg_cnt0_en_i;
      cnt1_en <= cfg_cnt1_en_i;
      pin_base <= eff_base;
      tick_src <= cfg_tick_src_i;
      prescale <= cfg_prescale_i;
    end
  end

  // Sticky error; a new error beats a clear in the same cycle
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_err_o <= 1'b0;
    end else if ((cfg_wr_i && cfg_bad) || (tmr_wr_i && tmr_bad)) begin
      cfg_err_o <= 1'b1; // [RL24]
    end else if (err_clr_i) begin
      cfg_err_o <= 1'b0;
    end
  end

  // Base rate per selector, halved on the oldest revision
  reg [16:0] src_khz;
  always @* begin
    case (tick_src)
      `SRC_4M: src_khz = `SRC_4MHZ_KHZ;
      `SRC_12M: src_khz = `SRC_12MHZ_KHZ;
      `SRC_48M: src_khz = `SRC_48MHZ_KHZ;
      `SRC_1M_DIV: src_khz = `SRC_1MHZ_KHZ;
      `SRC_4M_DIV: src_khz = `SRC_4MHZ_KHZ;
      `SRC_12M_DIV: src_khz = `SRC_12MHZ_KHZ;
      `SRC_48M_DIV: src_khz = `SRC_48MHZ_KHZ;
      default: src_khz = `SRC_48MHZ_KHZ;
    endcase
  end
  wire [16:0] inc = (rev == `REV_OLDEST) ? {1'b0, src_khz[16:1]} : src_khz; // [RL17] [RL15]

  // Phase accumulator: 48 MHz is not an integer fraction of 125 MHz,
  // so ticks carry one cycle of jitter but the right average rate
  reg [16:0] phase;
  wire [17:0] phase_sum = {1'b0, phase} + {1'b0, inc};
  wire base_hit = (phase_sum >= {1'b0, `CLK_SYS_KHZ});
  wire is_div = (tick_src >= `SRC_1M_DIV);
  reg [7:0] pre_cnt;
  wire pre_hit = (pre_cnt == prescale - 8'h01); // [RL16]

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= 17'h00000;
      pre_cnt <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      phase <= base_hit ? phase_sum[16:0] - `CLK_SYS_KHZ : phase_sum[16:0];
      if (cfg_wr_i && !cfg_bad) begin
        pre_cnt <= 8'h00;
      end else if (base_hit && is_div) begin
        pre_cnt <= pre_hit ? 8'h00 : pre_cnt + 8'h01;
      end
      // Fixed sources ignore the prescale
      tick_o <= base_hit && (!is_div || pre_hit); // [RL15]
    end
  end

  // First counter only exists on the fixed sources
  wire c0_act = cnt0_en && !is_div; // [RL6]

  // Channel line positions, packed in order
  wire [3:0] pos_t1 = pin_base + 4'h1;
  wire [3:0] pos_c0 = pin_base + {2'h0, tmr_num};
  wire [3:0] pos_c1 = pos_c0 + {3'h0, c0_act}; // [RL1] [RL7] [RL2]

  // Shared free-running period counter
  reg [15:0] pcnt;
  wire wrap16 = tick_o && (pcnt == 16'hFFFF);
  wire wrap8 = tick_o && (pcnt[7:0] == 8'hFF);
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pcnt <= 16'h0000;
    end else if (tick_o) begin
      pcnt <= pcnt + 16'h0001; // [RL20]
    end
  end

  // Per-timer PWM
  reg [15:0] duty [0:1];
  reg [1:0] run;
  reg [1:0] pwm_lvl;
  wire [1:0] is_pwm;
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_tmr
      wire wr_me = tmr_wr_i && !tmr_bad && (tmr_sel_i == t);
      wire pwm8 = (tmr_mode[t] == `MODE_PWM8);
      wire bound = pwm8 ? wrap8 : wrap16;
      assign is_pwm[t] = (tmr_mode[t] == `MODE_PWM16) || pwm8;
      always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          tmr_mode[t] <= `RST_TMR_MODE;
          tmr_pend[t] <= 16'h0000;
          duty[t] <= 16'h0000;
          run[t] <= 1'b0;
          pwm_lvl[t] <= 1'b1;
        end else begin
          if (wr_me) begin
            tmr_mode[t] <= tmr_mode_i;
            tmr_pend[t] <= tmr_value_i;
          end
          // Mode change restarts; duty alone waits for the boundary
          if (wr_me && (tmr_mode_i != tmr_mode[t])) begin
            run[t] <= 1'b0; // [RL22]
          end else if (bound) begin
            duty[t] <= tmr_pend[t]; // [RL23]
            run[t] <= is_pwm[t]; // [RL22]
          end
          // Low for the programmed count at the start of each period
          if (!run[t]) begin
            pwm_lvl[t] <= 1'b1;
          end else if (pwm8) begin
            pwm_lvl[t] <= !(pcnt[7:0] < duty[t][15:8]); // [RL19] [RL21]
          end else begin
            pwm_lvl[t] <= !(pcnt < duty[t]); // [RL18] [RL21]
          end
        end
      end
    end
  endgenerate

  // Line ownership map from the active configuration
  reg [15:0] line_tc;
  reg [15:0] line_drv;
  reg [15:0] line_val;
  always @* begin
    line_tc = 16'h0000;
    line_drv = 16'h0000;
    line_val = 16'hFFFF;
    if (tmr_num >= 2'h1) begin
      line_tc[pin_base] = 1'b1;
      line_drv[pin_base] = is_pwm[0];
      line_val[pin_base] = pwm_lvl[0];
    end
    if (tmr_num == 2'h2) begin
      line_tc[pos_t1] = 1'b1;
      line_drv[pos_t1] = is_pwm[1];
      line_val[pos_t1] = pwm_lvl[1];
    end
    if (c0_act) begin
      line_tc[pos_c0] = 1'b1;
    end
    if (cnt1_en) begin
      line_tc[pos_c1] = 1'b1;
    end
  end

  // Pin drive; free lines follow the host level, but released lines keep their direction until gpio_dir_wr_i
  reg [15:0] dir_hold;
  reg [15:0] held_oe_n;
  integer i;
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_out_o <= 16'hFFFF;
      io_oe_n_o <= 16'hFFFF;
      dir_hold <= 16'h0000;
      held_oe_n <= 16'hFFFF;
    end else begin
      for (i = 0; i < 16; i = i + 1) begin
        if (line_tc[i]) begin
          dir_hold[i] <= 1'b1;
          held_oe_n[i] <= !line_drv[i]; // [RL10]
          io_out_o[i] <= line_val[i];
          io_oe_n_o[i] <= !line_drv[i]; // [RL10]
        end else begin
          if (gpio_dir_wr_i) begin
            dir_hold[i] <= 1'b0;
          end
          io_out_o[i] <= gpio_out_i[i]; // [RL5]
          io_oe_n_o[i] <= dir_hold[i] ? held_oe_n[i] : gpio_oe_n_i[i]; // [RL10]
        end
      end
    end
  end

  // Edge counters
  wire [31:0] cnt_val0;
  wire [31:0] cnt_val1;
  edge_tally u_tally0 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .en_i(c0_act),
    .line_i(in_s[pos_c0]),
    .clr_i(cnt_rst_i && !cnt_sel_i),
    .count_o(cnt_val0)
  );
  edge_tally u_tally1 (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .en_i(cnt1_en),
    .line_i(in_s[pos_c1]),
    .clr_i(cnt_rst_i && cnt_sel_i),
    .count_o(cnt_val1)
  );

  // Read samples the count before a same-cycle reset lands
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_rd_data_o <= 32'h00000000;
      cnt_rd_vld_o <= 1'b0;
      cnt0_avail_o <= 1'b1;
    end else begin
      cnt_rd_vld_o <= cnt_rd_i;
      if (cnt_rd_i) begin
        cnt_rd_data_o <= cnt_sel_i ? cnt_val1 : cnt_val0; // [RL12]
      end
      cnt0_avail_o <= !is_div; // [RL6]
    end
  end

endmodule
